// ---- rtl/chopper_pkg.sv ----
// Constants, encodings and register map of the dual bridge chopper.
// Assumes a single 125 MHz clock domain for every user of the package.
package chopper_pkg;
	localparam int CLK_MHZ = 125;
	localparam int CNT_W = 12;
	localparam int NUM_BR = 2;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	// Blanking times in ns, rounded up to whole cycles
	localparam int BLANK_NS_0 = 600;
	localparam int BLANK_NS_1 = 900;
	localparam int BLANK_NS_2 = 1200;
	localparam int BLANK_NS_3 = 1500;
	localparam logic [CNT_W-1:0] BLANK_CYC_0 = CNT_W'((BLANK_NS_0 * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] BLANK_CYC_1 = CNT_W'((BLANK_NS_1 * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] BLANK_CYC_2 = CNT_W'((BLANK_NS_2 * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] BLANK_CYC_3 = CNT_W'((BLANK_NS_3 * CLK_MHZ + 999) / 1000);
	localparam logic [1:0] BLANK_SEL_RST = 2'h2;
	// Fast decay budget that a growing on phase eats into
	localparam int FAST_NS_RST = 2000;
	localparam logic [CNT_W-1:0] FAST_BASE_RST = CNT_W'((FAST_NS_RST * CLK_MHZ) / 1000);
	// Register map
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_FAST = 4'h8;
	localparam int CTRL_W = 3;
	localparam int CTRL_BL_LO = 0;
	localparam int CTRL_BL_HI = 1;
	localparam int CTRL_STBY = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = {1'b0, BLANK_SEL_RST};
	localparam int STAT_OC = 0;
	localparam int STAT_PHA = 1;
	localparam int STAT_PHB = 3;
	localparam int STAT_POLA = 5;
	localparam int STAT_POLB = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Gate vector {high1, high2, low1, low2}
	localparam logic [3:0] GATE_OFF = 4'h0;
	localparam logic [3:0] GATE_ON_LO = 4'h9;
	localparam logic [3:0] GATE_ON_HI = 4'h6;
	localparam logic [3:0] GATE_FAST_LO = 4'h2;
	localparam logic [3:0] GATE_FAST_HI = 4'h1;
	localparam logic [3:0] GATE_SLOW = 4'h3;
	typedef enum logic [1:0] {
		PH_SLOW = 2'b00,
		PH_ON = 2'b01,
		PH_FAST = 2'b10
	} chop_phase_e;
	function automatic logic [CNT_W-1:0] blank_cycles(input logic [1:0] code);
		case (code)
			2'h0: blank_cycles = BLANK_CYC_0;
			2'h1: blank_cycles = BLANK_CYC_1;
			2'h2: blank_cycles = BLANK_CYC_2;
			default: blank_cycles = BLANK_CYC_3;
		endcase
	endfunction
endpackage

// ---- rtl/bridge_if.sv ----
// Signals shared by the top, one bridge sequencer and its gate driver.
// Assumes all three sit on the same clock.
interface bridge_if;
	import chopper_pkg::*;
	logic start, pol, mix_en_n, sense_hit, kill;
	logic [CNT_W-1:0] blank_cyc, fast_base, on_cnt;
	logic pol_q, blank_zero;
	chop_phase_e phase;
	logic [3:0] gates;
	modport ctl (output start, pol, mix_en_n, sense_hit, kill, blank_cyc, fast_base,
		input phase, pol_q, blank_zero, on_cnt, gates);
	modport chop (input start, pol, mix_en_n, sense_hit, blank_cyc, fast_base,
		output phase, pol_q, blank_zero, on_cnt);
	modport drv (input phase, pol_q, kill, output gates);
endinterface

// ---- rtl/bridge_chopper.sv ----
// One bridge's on / fast / slow decay sequencer.
// Assumes start is a one-cycle pulse from the top at the bridge's clock edge.
module bridge_chopper import chopper_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	bridge_if.chop bus
);
	chop_phase_e phase_q;
	logic pol_q;
	logic [CNT_W-1:0] blank_q, fast_q, on_q, fast_len;
	logic restart, on_end;

	assign restart = bus.start || (bus.pol != pol_q);
	assign on_end = (phase_q == PH_ON) && (blank_q == '0) && bus.sense_hit;
	// Longer on phase leaves less fast decay; disabled mix means none
	assign fast_len = (bus.mix_en_n || on_q >= bus.fast_base) ? '0 : bus.fast_base - on_q;

	always_ff @(posedge clk) begin
		if (!rstn)
			pol_q <= 1'b0;
		else if (ce)
			pol_q <= bus.pol;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			phase_q <= PH_SLOW;
		end else if (ce) begin
			if (restart) begin
				phase_q <= PH_ON;
			end else begin
				case (phase_q)
					PH_ON: if (on_end) phase_q <= (fast_len == '0) ? PH_SLOW : PH_FAST;
					PH_FAST: if (fast_q <= CNT_ONE) phase_q <= PH_SLOW;
					PH_SLOW: phase_q <= PH_SLOW;
					default: phase_q <= PH_SLOW;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			blank_q <= '0;
		else if (ce && restart)
			blank_q <= bus.blank_cyc;
		else if (ce && phase_q == PH_ON && blank_q != '0)
			blank_q <= blank_q - CNT_ONE;
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			on_q <= '0;
		else if (ce && restart)
			on_q <= '0;
		else if (ce && phase_q == PH_ON && on_q != '1)
			on_q <= on_q + CNT_ONE;
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			fast_q <= '0;
		else if (ce && !restart && on_end)
			fast_q <= fast_len;
		else if (ce && phase_q == PH_FAST && fast_q != '0)
			fast_q <= fast_q - CNT_ONE;
	end

	assign bus.phase = phase_q;
	assign bus.pol_q = pol_q;
	assign bus.blank_zero = (blank_q == '0);
	assign bus.on_cnt = on_q;
endmodule // bridge_chopper

// ---- rtl/gate_driver.sv ----
// Registered switch pattern for one bridge from phase and polarity.
// Assumes kill already merges standby and the overcurrent flag.
module gate_driver import chopper_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	bridge_if.drv bus
);
	logic [3:0] gates_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			gates_q <= GATE_OFF;
		end else if (ce) begin
			if (bus.kill) begin
				gates_q <= GATE_OFF;
			end else begin
				case (bus.phase)
					PH_ON: gates_q <= bus.pol_q ? GATE_ON_HI : GATE_ON_LO;
					PH_FAST: gates_q <= bus.pol_q ? GATE_FAST_HI : GATE_FAST_LO;
					PH_SLOW: gates_q <= GATE_SLOW;
					default: gates_q <= GATE_OFF;
				endcase
			end
		end
	end

	assign bus.gates = gates_q;
endmodule // gate_driver

// ---- rtl/chopper_top.sv ----
// Top of the dual bridge chopper: oscillator edges, fault latch, AXI4-Lite registers.
// Assumes all pins are synchronous to clk and the oscillator input never floats.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
module chopper_top import chopper_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic osc_clk_in,
	input wire logic coil_a_polarity,
	input wire logic coil_b_polarity,
	input wire logic decay_mix_en_a_n,
	input wire logic decay_mix_en_b_n,
	input wire logic current_sense_a,
	input wire logic current_sense_b,
	input wire logic hs_drop_exceeded,
	output logic [3:0] gate_a,
	output logic [3:0] gate_b,
	output logic fault_out,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [STRB_W-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_FAST);
	endfunction

	function automatic logic [DATA_W-1:0] merge_strb(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [STRB_W-1:0] strb);
		logic [DATA_W-1:0] m;
		m = old_v;
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i])
				m[i*8 +: 8] = new_v[i*8 +: 8];
		end
		merge_strb = m;
	endfunction

	logic osc_q, osc_rise, osc_fall;
	logic oc_flag_q, kill;
	logic [CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0] fast_base_q;
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q, wr_fire, rd_fire;
	logic [ADDR_W-1:0] awaddr_q;
	logic [DATA_W-1:0] wdata_q, rdata_q, stat_w, rd_mux;
	logic [STRB_W-1:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [NUM_BR-1:0] start_w, pol_w, mix_w, sense_w;
	logic restart_a, restart_b;

	// Oscillator pin is taken as synchronous; edges become start pulses
	always_ff @(posedge clk) begin
		if (!rstn)
			osc_q <= 1'b0;
		else if (ce)
			osc_q <= osc_clk_in;
	end

	assign osc_rise = osc_clk_in && !osc_q;
	assign osc_fall = !osc_clk_in && osc_q;

	// Rise and fall of one clock give the half-period offset
	assign start_w = {osc_fall, osc_rise};
	assign pol_w = {coil_b_polarity, coil_a_polarity};
	assign mix_w = {decay_mix_en_b_n, decay_mix_en_a_n};
	assign sense_w = {current_sense_b, current_sense_a};

	// Fault latch; a new fault beats a standby clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rstn)
			oc_flag_q <= 1'b0;
		else if (ce && hs_drop_exceeded)
			oc_flag_q <= 1'b1;
		else if (ce && ctrl_q[CTRL_STBY])
			oc_flag_q <= 1'b0;
	end

	assign kill = oc_flag_q || ctrl_q[CTRL_STBY];
	assign fault_out = oc_flag_q;

	bridge_if br[NUM_BR] ();

	generate
		for (genvar i = 0; i < NUM_BR; i++) begin : g_br
			assign br[i].start = start_w[i];
			assign br[i].pol = pol_w[i];
			assign br[i].mix_en_n = mix_w[i];
			assign br[i].sense_hit = sense_w[i];
			assign br[i].kill = kill;
			assign br[i].blank_cyc = blank_cycles({ctrl_q[CTRL_BL_HI], ctrl_q[CTRL_BL_LO]});
			assign br[i].fast_base = fast_base_q;
			bridge_chopper u_chop (
				.clk(clk),
				.rstn(rstn),
				.ce(ce),
				.bus(br[i])
			);
			gate_driver u_gate (
				.clk(clk),
				.rstn(rstn),
				.ce(ce),
				.bus(br[i])
			);
		end
	endgenerate

	assign gate_a = br[0].gates;
	assign gate_b = br[1].gates;

	// Write path: address and data may arrive in either order
	assign awready = !aw_hold_q;
	assign wready = !w_hold_q;
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_hold_q <= 1'b0;
			awaddr_q <= '0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			w_hold_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (ce) begin
			if (wvalid && wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= reg_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// Control register: blank select and standby
	always_ff @(posedge clk) begin
		if (!rstn)
			ctrl_q <= CTRL_RST;
		else if (ce && wr_fire && awaddr_q == OFS_CTRL)
			ctrl_q <= CTRL_W'(merge_strb(DATA_W'(ctrl_q), wdata_q, wstrb_q));
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			fast_base_q <= FAST_BASE_RST;
		else if (ce && wr_fire && awaddr_q == OFS_FAST)
			fast_base_q <= CNT_W'(merge_strb(DATA_W'(fast_base_q), wdata_q, wstrb_q));
	end

	// Status shows live phases, sampled polarities and the fault latch
	always_comb begin
		stat_w = '0;
		stat_w[STAT_OC] = oc_flag_q;
		stat_w[STAT_PHA +: 2] = br[0].phase;
		stat_w[STAT_PHB +: 2] = br[1].phase;
		stat_w[STAT_POLA] = br[0].pol_q;
		stat_w[STAT_POLB] = br[1].pol_q;
	end

	always_comb begin
		case (araddr)
			OFS_CTRL: rd_mux = DATA_W'(ctrl_q);
			OFS_STAT: rd_mux = stat_w;
			OFS_FAST: rd_mux = DATA_W'(fast_base_q);
			default: rd_mux = '0;
		endcase
	end

	assign arready = !rvalid_q;
	assign rd_fire = arvalid && arready;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Helper terms for the checks below
	assign restart_a = osc_rise || (coil_a_polarity != br[0].pol_q);
	assign restart_b = osc_fall || (coil_b_polarity != br[1].pol_q);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Start edges; a start of A must leave a resting B alone
	a_start_edge_a: assert property (
		ce && osc_rise
		|=> br[0].phase == PH_ON)
		else $error("bridge A did not start on oscillator rise");
	a_start_edge_b: assert property (
		ce && osc_fall
		|=> br[1].phase == PH_ON)
		else $error("bridge B did not start on oscillator fall");
	a_half_offset: assert property (
		ce && osc_rise && br[1].phase == PH_SLOW
		&& coil_b_polarity == br[1].pol_q
		|=> br[1].phase == PH_SLOW)
		else $error("bridge A start disturbed bridge B");

	// Phase order and switch patterns
	a_fast_no_on: assert property (
		ce && br[0].phase == PH_FAST && !restart_a
		|=> br[0].phase != PH_ON)
		else $error("fast decay went back to on without restart");
	a_fast_gates: assert property (
		ce && br[0].phase == PH_FAST && !kill
		|=> gate_a == ($past(br[0].pol_q) ? GATE_FAST_HI : GATE_FAST_LO))
		else $error("wrong switches in fast decay");
	a_fast_gates_b: assert property (
		ce && br[1].phase == PH_FAST && !kill
		|=> gate_b == ($past(br[1].pol_q) ? GATE_FAST_HI : GATE_FAST_LO))
		else $error("wrong switches in bridge B fast decay");
	a_slow_gates: assert property (
		ce && br[1].phase == PH_SLOW && !kill
		|=> gate_b == GATE_SLOW)
		else $error("slow decay did not close both low sides");

	// Polarity restart
	a_pol_restart: assert property (
		ce && coil_a_polarity != br[0].pol_q
		|=> br[0].phase == PH_ON && !br[0].blank_zero)
		else $error("polarity change did not restart bridge A");
	a_pol_isolated: assert property (
		ce && coil_a_polarity != br[0].pol_q && !restart_b
		&& br[1].phase == PH_SLOW
		|=> br[1].phase == PH_SLOW)
		else $error("bridge A polarity change disturbed bridge B");

	// Termination, blanking and mixed decay
	a_on_terminate: assert property (
		ce && br[0].phase == PH_ON && br[0].blank_zero
		&& current_sense_a && !restart_a
		|=> br[0].phase != PH_ON)
		else $error("on phase kept after target current");
	a_mix_shorten: assert property (
		ce && br[0].phase == PH_ON && br[0].blank_zero
		&& current_sense_a && !decay_mix_en_a_n
		&& br[0].on_cnt >= fast_base_q && !restart_a
		|=> br[0].phase == PH_SLOW)
		else $error("long on phase still got fast decay");
	a_mix_off: assert property (
		ce && br[1].phase == PH_ON && decay_mix_en_b_n && !restart_b
		|=> br[1].phase != PH_FAST)
		else $error("fast decay with mixed decay disabled");
	a_blank_hold: assert property (
		ce && br[0].phase == PH_ON && !br[0].blank_zero
		&& !restart_a
		|=> br[0].phase == PH_ON)
		else $error("on phase ended during blanking");
	a_slow_hold: assert property (
		ce && br[0].phase == PH_SLOW && !restart_a
		|=> br[0].phase == PH_SLOW)
		else $error("slow decay left before next start");

	// Reset defaults and fault latch
	a_blank_reset: assert property (
		$rose(rstn)
		|-> ctrl_q[CTRL_BL_HI:CTRL_BL_LO] == BLANK_SEL_RST)
		else $error("blank select not at default after reset");
	a_oc_latch: assert property (
		ce && hs_drop_exceeded
		|=> fault_out)
		else $error("overcurrent not flagged");
	a_oc_kill: assert property (
		ce && oc_flag_q
		|=> gate_a == GATE_OFF && gate_b == GATE_OFF)
		else $error("switches on while fault latched");

	// Main scenarios
	c_fast_phase: cover property (br[0].phase == PH_ON ##1 br[0].phase == PH_FAST);
	c_pol_restart: cover property (ce && coil_b_polarity != br[1].pol_q && br[1].phase == PH_SLOW);
	c_fault_clear: cover property (oc_flag_q ##1 !oc_flag_q);
	c_write_resp: cover property (bvalid && bready);
	c_b_fast: cover property (br[1].phase == PH_FAST);
endmodule // chopper_top

// ---- dv/host_model.sv ----
// Host side: chopper oscillator square wave and coil A polarity, plain or as PWM.
// Assumes the bench clock; the oscillator toggles every HALF cycles of it.
module host_model #(parameter int HALF = 625) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pwm_en,
	input wire logic [7:0] pwm_duty,
	input wire logic pol_cmd,
	output logic osc_clk_in,
	output logic coil_a_polarity
);
	timeunit 1ns;
	timeprecision 1ps;
	int osc_cnt;
	logic [7:0] pwm_cnt;
	// Driven from reset on, never left open; 625 keeps it at 100 kHz
	always_ff @(posedge clk) begin
		if (!rstn) begin
			osc_cnt <= 0;
			osc_clk_in <= 1'h0;
		end else if (osc_cnt == HALF - 1) begin
			osc_cnt <= 0;
			osc_clk_in <= ~osc_clk_in;
		end else begin
			osc_cnt <= osc_cnt + 1;
		end
	end
	// Duty over 256 cycles; 128 means zero mean current
	always_ff @(posedge clk) begin
		pwm_cnt <= rstn ? pwm_cnt + 8'h01 : 8'h00;
		coil_a_polarity <= pwm_en ? (pwm_cnt < pwm_duty) : pol_cmd;
	end
endmodule // host_model

// ---- dv/tb_top.sv ----
// Self-checking bench for chopper_top: oscillator and coil A polarity through host_model, other pins driven directly, registers over AXI4-Lite.
// Assumes one 125 MHz clock and the gate encodings of chopper_pkg.
module tb_top import chopper_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 625;
	logic clk = 1'h0, rstn = 1'h0, ce = 1'h1, pwm_en = 1'h0, pol_cmd = 1'h0, pol_b = 1'h0;
	logic mix_a_n = 1'h1, mix_b_n = 1'h1, sense_a = 1'h0, sense_b = 1'h0, hs_drop = 1'h0;
	logic [7:0] duty = 8'h80;
	logic osc, osc_q, pol_a, fault_out, awready, wready, bvalid, arready, rvalid;
	logic [3:0] gate_a, gate_b;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [STRB_W-1:0] wstrb = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [1:0] bresp, rresp;
	int n_fail = 0, checks_done = 0, cyc = 0, fbase = 250;
	initial begin
		forever #4 clk = ~clk;
	end
	host_model #(.HALF(HALF)) u_host_model (.clk(clk), .rstn(rstn), .pwm_en(pwm_en),
		.pwm_duty(duty), .pol_cmd(pol_cmd), .osc_clk_in(osc), .coil_a_polarity(pol_a));
	chopper_top u_chopper_top (.clk(clk), .rstn(rstn), .ce(ce), .osc_clk_in(osc),
		.coil_a_polarity(pol_a), .coil_b_polarity(pol_b), .decay_mix_en_a_n(mix_a_n),
		.decay_mix_en_b_n(mix_b_n), .current_sense_a(sense_a), .current_sense_b(sense_b),
		.hs_drop_exceeded(hs_drop), .gate_a(gate_a), .gate_b(gate_b), .fault_out(fault_out),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Runs near 44k cycles; the ceiling leaves headroom
	always @(posedge clk) begin
		osc_q <= osc;
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_rng(input string what, input int lo, input int hi, input int g);
		checks_done++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, g);
		end
	endtask
	function automatic int blank_exp(input int code);
		return ((600 + 300 * code) * 125 + 999) / 1000;
	endfunction
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw_ok = 1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				w_ok = 1;
				wvalid <= 1'h0;
			end
		end while (!(aw_ok && w_ok));
		do @(posedge clk); while (!bvalid);
		bready <= 1'h0;
		chk_val("bresp", 32'(er), 32'(bresp));
		// Idle edge so a following call never flips a ready twice in one step
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'h0;
		chk_val("rdata", e, rdata);
		chk_val("rresp", 32'(er), 32'(rresp));
		@(posedge clk);
	endtask
	task automatic wait_rise();
		do @(posedge clk); while (!(osc && !osc_q));
	endtask
	// One bridge A period from a rising oscillator edge to the next
	task automatic run_a(input logic p, input logic mn, input int sdel, input int blank);
		int k, s, stage, n_on, n_fast, n_slow, n_bad, b_on, e_on, e_fast;
		logic [3:0] on_p, fast_p;
		k = 0;
		stage = 0;
		n_on = 0;
		n_fast = 0;
		n_slow = 0;
		n_bad = 0;
		b_on = -1;
		pol_cmd <= p;
		mix_a_n <= mn;
		sense_b <= 1'h1;
		on_p = p ? GATE_ON_HI : GATE_ON_LO;
		fast_p = p ? GATE_FAST_HI : GATE_FAST_LO;
		wait_rise();
		do begin
			sense_a <= (k >= sdel);
			@(posedge clk);
			k++;
			s = gate_a == on_p ? 1 : gate_a == fast_p ? 2 : gate_a == GATE_SLOW ? 3 : 0;
			if (s == 1 && stage == 0) stage = 1;
			if (stage > 0) begin
				if (s < stage) n_bad++;
				else stage = s;
				n_on += int'(s == 1);
				n_fast += int'(s == 2);
				n_slow += int'(s == 3);
			end
			if (k > HALF - 20 && b_on < 0 && (gate_b == GATE_ON_LO || gate_b == GATE_ON_HI))
				b_on = k;
		end while (!(osc && !osc_q));
		sense_a <= 1'h0;
		e_on = sdel > blank ? sdel : blank;
		e_fast = (!mn && n_on < fbase) ? fbase - n_on : 0;
		chk_rng("on cycles", e_on - 2, e_on + 4, n_on);
		chk_rng("fast cycles", e_fast - 2, e_fast + 2, n_fast);
		chk_rng("phase order faults", 0, 0, n_bad);
		chk_rng("slow cycles", 1, 2 * HALF, n_slow);
		chk_rng("bridge b start", HALF, HALF + 4, b_on);
		chk_rng("period", 2 * HALF, 2 * HALF, k);
		$display("Test cycle pol %0d mix_n %0d delay %0d done", p, mn, sdel);
	endtask
	task automatic pwm_test(input int d);
		int n_hi, n_lo;
		n_hi = 0;
		n_lo = 0;
		duty <= 8'(d);
		pwm_en <= 1'h1;
		mix_a_n <= 1'h1;
		repeat (256) @(posedge clk);
		repeat (1024) begin
			@(posedge clk);
			n_hi += int'(gate_a == GATE_ON_HI);
			n_lo += int'(gate_a == GATE_ON_LO);
		end
		pwm_en <= 1'h0;
		@(posedge clk);
		chk_rng("pwm high share", 4 * d - 12, 4 * d + 12, n_hi);
		chk_rng("pwm low share", 1012 - 4 * d, 1036 - 4 * d, n_lo);
		$display("Test pwm duty %0d done", d);
	endtask
	initial begin
		int c;
		void'($urandom(4));
		repeat (3) @(posedge clk);
		chk_val("gate a in reset", 32'h0, 32'(gate_a));
		rstn <= 1'h1;
		axi_rd(OFS_CTRL, 32'h2, RESP_OKAY);
		axi_rd(OFS_FAST, 32'hfa, RESP_OKAY);
		axi_rd(4'hc, 32'h0, RESP_SLVERR);
		axi_wr(OFS_STAT, 32'h1, RESP_OKAY);
		$display("Test registers done");
		for (c = 0; c < 4; c++) begin
			axi_wr(OFS_CTRL, 32'(c), RESP_OKAY);
			run_a(1'h0, 1'h0, 0, blank_exp(c));
		end
		axi_wr(OFS_CTRL, 32'h2, RESP_OKAY);
		run_a(1'h1, 1'h0, 240, 150);
		@(posedge clk);
		sense_a <= 1'h1;
		wait_rise();
		repeat (400) @(posedge clk);
		chk_val("gate a slow", 32'(GATE_SLOW), 32'(gate_a));
		pol_cmd <= 1'h0;
		repeat (5) @(posedge clk);
		chk_val("gate a restart", 32'(GATE_ON_LO), 32'(gate_a));
		chk_val("gate b kept", 32'(GATE_SLOW), 32'(gate_b));
		sense_a <= 1'h0;
		$display("Test polarity restart done");
		hs_drop <= 1'h1;
		@(posedge clk);
		hs_drop <= 1'h0;
		repeat (1300) @(posedge clk);
		chk_val("fault flag", 32'h1, 32'(fault_out));
		chk_val("gates off", 32'h0, 32'({gate_a, gate_b}));
		// Bridge A still sits in its on phase with sense low; only the gates are off
		axi_rd(OFS_STAT, 32'h3, RESP_OKAY);
		axi_wr(OFS_CTRL, 32'h6, RESP_OKAY);
		axi_wr(OFS_CTRL, 32'h2, RESP_OKAY);
		chk_val("fault cleared", 32'h0, 32'(fault_out));
		$display("Test overcurrent done");
		for (c = 64; c < 256; c += 64) pwm_test(c);
		axi_wr(OFS_FAST, 32'hc8, RESP_OKAY);
		fbase = 200;
		axi_rd(OFS_FAST, 32'hc8, RESP_OKAY);
		repeat (10) begin
			pol_b <= 1'($urandom % 2);
			mix_b_n <= 1'($urandom % 2);
			run_a(1'($urandom % 2), 1'($urandom % 2), $urandom % 500, 150);
		end
		print_verdict();
	end
endmodule // tb_top
